// >>> hdl/tafg_pkg.sv
package tafg_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_NS = 20; // system clock period
  localparam int NS_PER_SEC = 1000000000; // nanoseconds in a second
  localparam int SYNC_STAGES = 3; // reset conditioning depth
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [31:0] OFS_CONTROL = 32'h00000000; // enable and valid
  localparam logic [31:0] OFS_STATUS = 32'h00000004; // in-phase flags
  localparam logic [31:0] OFS_POLARITY = 32'h00000008; // polarity
  localparam logic [31:0] OFS_VERSION = 32'h0000000C; // version
  localparam logic [31:0] OFS_CABLE = 32'h00000020; // cable delay
  localparam logic [31:0] OFS_FREQ = 32'h00000030; // frequency
  localparam logic [31:0] OFS_CYCLES = 32'h00000034; // cycles per second
  localparam logic [31:0] WINDOW_SPAN = 32'h0000FFFF; // default window size
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE = 0; // control enable bit
  localparam int BIT_FREQ_VAL = 1; // control valid bit
  localparam int BIT_IN_PHASE = 0; // status in-phase bit
  localparam int BIT_SKIP = 1; // status skip bit
  localparam int BIT_PHASE_ERR = 8; // status sticky error bit
  localparam logic [31:0] VERSION_VALUE = 32'h01000000; // arbitrary value
  localparam logic [1:0] RESP_OKAY = 2'h0; // bus answer ok
  localparam logic [1:0] RESP_DECERR = 2'h3; // bus answer decode error
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] second; // seconds
    logic [31:0] nanosecond; // nanoseconds
    logic [1:0] fraction; // fraction numerator
    logic sign; // 1 means negative
    logic discontinuityMarker; // time jump
  } tafg_time_t;
  typedef struct packed {
    logic polarity; // 1 active high
    logic [15:0] cableDelay; // nanoseconds
    logic [23:0] frequency; // hertz
  } tafg_setup_t;
  typedef struct packed {
    logic enable; // generation on
    logic valid; // values valid
  } tafg_flags_t;
endpackage

// >>> hdl/tafg_link_if.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// link between the time source side and the generator
// ------------------------------------------------------------------
interface tafg_link_if;
  tafg_pkg::tafg_time_t refTimeIn; // reference time
  logic refTimeOkIn; // time valid
  tafg_pkg::tafg_setup_t fixedSetupBundle; // static config
  tafg_pkg::tafg_flags_t fixedSetupFlags; // static flags
  logic awvalid;
  logic awready;
  logic [31:0] awaddr;
  logic [2:0] awprot;
  logic wvalid;
  logic wready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic bvalid;
  logic bready;
  logic [1:0] bresp;
  logic arvalid;
  logic arready;
  logic [31:0] araddr;
  logic [2:0] arprot;
  logic rvalid;
  logic rready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic phaseLockedOut; // in-phase status
  logic waveOut; // generated signal
  modport device (
    input refTimeIn, refTimeOkIn, fixedSetupBundle, fixedSetupFlags,
    input awvalid, awaddr, awprot, wvalid, wdata, wstrb, bready,
    input arvalid, araddr, arprot, rready,
    output awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp,
    output phaseLockedOut, waveOut
  );
  modport host (
    output refTimeIn, refTimeOkIn, fixedSetupBundle, fixedSetupFlags,
    output awvalid, awaddr, awprot, wvalid, wdata, wstrb, bready,
    output arvalid, araddr, arprot, rready,
    input awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp,
    input phaseLockedOut, waveOut
  );
endinterface

// >>> hdl/tafg_host.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// far end: time source counter, static setup, bus master for a port
// ------------------------------------------------------------------
module tafg_host #(
  parameter int SYS_PERIOD = tafg_pkg::SYS_PERIOD_NS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  tafg_link_if.host link,
  input wire logic [31:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdData,
  output logic busErr,
  input wire logic timeLoad,
  input wire logic [31:0] timeLoadSec,
  input wire logic [31:0] timeLoadNs,
  input wire tafg_pkg::tafg_setup_t setupIn,
  input wire logic setupEnable,
  input wire logic setupValid,
  output logic phaseLocked,
  output logic wave
);
  // ----------------------------------------------------------------
  // counter clock
  // ----------------------------------------------------------------
  logic [31:0] sec;
  logic [31:0] ns;
  logic jump;
  wire nsWrap = ns >= 32'(tafg_pkg::NS_PER_SEC - SYS_PERIOD);
  // time advances one period per clock, loads mark a jump
  always_ff @(posedge mclk)
    if (!resetn)
    begin
      sec <= 32'h00000000;
      ns <= 32'h00000000;
      jump <= 1'b0;
    end
    else if (clkEn)
    begin
      jump <= timeLoad;
      if (timeLoad)
      begin
        sec <= timeLoadSec;
        ns <= timeLoadNs;
      end
      else if (nsWrap)
      begin
        sec <= sec + 32'h00000001;
        ns <= 32'h00000000;
      end
      else
        ns <= ns + 32'(SYS_PERIOD);
    end
  assign link.refTimeIn = '{sec, ns, 2'h0, 1'b0, jump};
  assign link.refTimeOkIn = resetn;
  assign link.fixedSetupBundle = setupIn;
  assign link.fixedSetupFlags = '{setupEnable, setupValid};
  // ----------------------------------------------------------------
  // bus master: one outstanding access at a time
  // ----------------------------------------------------------------
  logic aw;
  logic w;
  logic ar;
  // raise valids on a strobe, drop them once accepted
  always_ff @(posedge mclk)
    if (!resetn)
    begin
      aw <= 1'b0;
      w <= 1'b0;
      ar <= 1'b0;
      link.awaddr <= 32'h00000000;
      link.araddr <= 32'h00000000;
      link.wdata <= 32'h00000000;
      rdData <= 32'h00000000;
      busErr <= 1'b0;
    end
    else if (clkEn)
    begin
      if (wrStb)
      begin
        aw <= 1'b1;
        w <= 1'b1;
        link.awaddr <= addr;
        link.wdata <= wrData;
      end
      else
      begin
        if (link.awready)
          aw <= 1'b0;
        if (link.wready)
          w <= 1'b0;
      end
      if (rdStb)
      begin
        ar <= 1'b1;
        link.araddr <= addr;
      end
      else if (link.arready)
        ar <= 1'b0;
      if (link.rvalid)
        rdData <= link.rdata;
      if (link.rvalid || link.bvalid)
        busErr <= (link.rvalid ? link.rresp : link.bresp) != tafg_pkg::RESP_OKAY;
    end
  assign link.awvalid = aw;
  assign link.wvalid = w;
  assign link.arvalid = ar;
  assign link.awprot = 3'h0;
  assign link.arprot = 3'h0;
  assign link.wstrb = 4'hF;
  assign link.bready = 1'b1;
  assign link.rready = 1'b1;
  assign phaseLocked = link.phaseLockedOut;
  assign wave = link.waveOut;
endmodule

// >>> hdl/tafg_device.sv
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
// ------------------------------------------------------------------
// time aligned frequency generator with register slave
// ------------------------------------------------------------------
module tafg_device #(
  parameter bit reset_sync_stage_option = 1'b1,
  parameter bit fixed_setup_select = 1'b0,
  parameter int sys_period_ns_param = tafg_pkg::SYS_PERIOD_NS,
  parameter bit wire_delay_option = 1'b1,
  parameter int pin_path_delay_ns_param = 0,
  parameter bit default_active_level = 1'b1,
  parameter bit half_duty_select = 1'b1,
  parameter bit fine_clock_option = 1'b0,
  parameter int fine_clock_ratio = 5,
  parameter logic [31:0] bus_window_base = 32'h00000000,
  parameter logic [31:0] bus_window_top = bus_window_base + tafg_pkg::WINDOW_SPAN
) (
  input wire logic mclk,
  input wire logic fine_clock_in,
  input wire logic resetn,
  input wire logic clkEn,
  tafg_link_if.device link
);
  // ----------------------------------------------------------------
  // reset conditioning
  // ----------------------------------------------------------------
  logic [tafg_pkg::SYNC_STAGES-1:0] rstPipe;
  wire rstInt = reset_sync_stage_option ? rstPipe[tafg_pkg::SYNC_STAGES-1] : resetn;
  // shift ones in after release
  always_ff @(posedge mclk)
    if (!resetn)
      rstPipe <= '0;
    else if (clkEn)
      rstPipe <= {rstPipe[tafg_pkg::SYNC_STAGES-2:0], 1'b1};
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic regEnable;
  logic regValid;
  logic regPol;
  logic [15:0] regCable;
  logic [23:0] regFreq;
  logic phaseErr;
  logic skipFlag;
  logic [23:0] cyclesLast;
  logic inPhase;
  logic wave;
  logic [31:0] awAddr;
  logic awHave;
  logic [31:0] wData;
  logic wHave;
  logic bValid;
  logic [1:0] bResp;
  logic rValid;
  logic [31:0] rData;
  logic [1:0] rResp;
  // address decode
  wire [31:0] wOfs = awAddr - bus_window_base;
  wire [31:0] rOfs = link.araddr - bus_window_base;
  wire wInWin = awAddr >= bus_window_base && awAddr <= bus_window_top;
  wire rInWin = link.araddr >= bus_window_base && link.araddr <= bus_window_top;
  wire doWrite = awHave && wHave && !bValid;
  wire wKnown = wOfs == tafg_pkg::OFS_CONTROL || wOfs == tafg_pkg::OFS_STATUS ||
    wOfs == tafg_pkg::OFS_POLARITY || wOfs == tafg_pkg::OFS_CABLE || wOfs == tafg_pkg::OFS_FREQ;
  wire wOk = wInWin && wKnown;
  wire [31:0] rMux =
    rOfs == tafg_pkg::OFS_CONTROL ? {30'h0, regValid, regEnable} :
    rOfs == tafg_pkg::OFS_STATUS ? {23'h0, phaseErr, 6'h0, skipFlag, inPhase} :
    rOfs == tafg_pkg::OFS_POLARITY ? {31'h0, regPol} :
    rOfs == tafg_pkg::OFS_VERSION ? tafg_pkg::VERSION_VALUE :
    rOfs == tafg_pkg::OFS_CABLE ? {16'h0, regCable} :
    rOfs == tafg_pkg::OFS_FREQ ? {8'h0, regFreq} :
    {8'h0, cyclesLast};
  wire rKnown = rOfs == tafg_pkg::OFS_CONTROL || rOfs == tafg_pkg::OFS_STATUS ||
    rOfs == tafg_pkg::OFS_POLARITY || rOfs == tafg_pkg::OFS_VERSION ||
    rOfs == tafg_pkg::OFS_CABLE || rOfs == tafg_pkg::OFS_FREQ || rOfs == tafg_pkg::OFS_CYCLES;
  assign link.awready = !awHave;
  assign link.wready = !wHave;
  assign link.arready = !rValid;
  assign link.bvalid = bValid;
  assign link.bresp = bResp;
  assign link.rvalid = rValid;
  assign link.rdata = rData;
  assign link.rresp = rResp;
  // error flag: set wins over clear
  wire errSet;
  wire errClr = doWrite && wOk && wOfs == tafg_pkg::OFS_STATUS && wData[tafg_pkg::BIT_PHASE_ERR];
  // bus slave channels and register writes
  always_ff @(posedge mclk)
    if (!rstInt)
    begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddr <= 32'h00000000;
      wData <= 32'h00000000;
      bValid <= 1'b0;
      bResp <= tafg_pkg::RESP_OKAY;
      rValid <= 1'b0;
      rData <= 32'h00000000;
      rResp <= tafg_pkg::RESP_OKAY;
      regEnable <= 1'b0;
      regValid <= 1'b0;
      regPol <= default_active_level;
      regCable <= 16'h0000;
      regFreq <= 24'h000000;
      phaseErr <= 1'b0;
    end
    else if (clkEn)
    begin
      if (link.awvalid && !awHave)
      begin
        awHave <= 1'b1;
        awAddr <= link.awaddr;
      end
      if (link.wvalid && !wHave)
      begin
        wHave <= 1'b1;
        wData <= link.wdata;
      end
      if (doWrite)
      begin
        awHave <= 1'b0;
        wHave <= 1'b0;
        bValid <= 1'b1;
        bResp <= wOk ? tafg_pkg::RESP_OKAY : tafg_pkg::RESP_DECERR;
        if (wOk && wOfs == tafg_pkg::OFS_CONTROL)
        begin
          regEnable <= wData[tafg_pkg::BIT_ENABLE];
          regValid <= wData[tafg_pkg::BIT_FREQ_VAL];
        end
        if (wOk && wOfs == tafg_pkg::OFS_POLARITY)
          regPol <= wData[0];
        if (wOk && wOfs == tafg_pkg::OFS_CABLE)
          regCable <= wData[15:0];
        if (wOk && wOfs == tafg_pkg::OFS_FREQ)
          regFreq <= wData[23:0];
      end
      else if (bValid && link.bready)
        bValid <= 1'b0;
      if (link.arvalid && !rValid)
      begin
        rValid <= 1'b1;
        rData <= (rInWin && rKnown) ? rMux : 32'h00000000;
        rResp <= (rInWin && rKnown) ? tafg_pkg::RESP_OKAY : tafg_pkg::RESP_DECERR;
      end
      else if (rValid && link.rready)
        rValid <= 1'b0;
      if (errSet)
        phaseErr <= 1'b1;
      else if (errClr)
        phaseErr <= 1'b0;
    end
  // ----------------------------------------------------------------
  // configuration source select
  // ----------------------------------------------------------------
  wire cfgEnable = fixed_setup_select ? link.fixedSetupFlags.enable : regEnable;
  wire cfgValid = fixed_setup_select ? link.fixedSetupFlags.valid : regValid;
  logic cfgPol;
  logic [15:0] cfgCable;
  logic [23:0] cfgFreq;
  logic run;
  // static values are latched only while flagged valid
  always_ff @(posedge mclk)
    if (!rstInt)
    begin
      cfgPol <= default_active_level;
      cfgCable <= 16'h0000;
      cfgFreq <= 24'h000000;
    end
    else if (clkEn && cfgValid && !run)
    begin
      cfgPol <= fixed_setup_select ? link.fixedSetupBundle.polarity : regPol;
      cfgCable <= fixed_setup_select ? link.fixedSetupBundle.cableDelay : regCable;
      cfgFreq <= fixed_setup_select ? link.fixedSetupBundle.frequency : regFreq;
    end
  // ----------------------------------------------------------------
  // generator: phase accumulator in nanoseconds
  // ----------------------------------------------------------------
  localparam int STEP_NS = fine_clock_option ? sys_period_ns_param : sys_period_ns_param;
  wire halfDuty = half_duty_select || fine_clock_option;
  wire goodCfg = cfgEnable && cfgValid && cfgFreq != 24'h000000 && link.refTimeOkIn;
  wire [31:0] leadNs = 32'(pin_path_delay_ns_param) +
    (wire_delay_option ? {16'h0, cfgCable} : 32'h0);
  wire [31:0] nsLate = link.refTimeIn.nanosecond + leadNs + 32'(STEP_NS);
  wire secEdge = nsLate >= 32'(tafg_pkg::NS_PER_SEC) &&
    link.refTimeIn.nanosecond + leadNs < 32'(tafg_pkg::NS_PER_SEC);
  // accumulator counts freq*step per clock; period is 1e9
  logic [55:0] acc;
  logic [23:0] cycCount;
  wire [55:0] accNext = acc + 56'(cfgFreq) * 56'(STEP_NS);
  wire wrap = accNext >= 56'(tafg_pkg::NS_PER_SEC);
  wire [55:0] accHalf = 56'(tafg_pkg::NS_PER_SEC / 2);
  wire [55:0] accWrapped = accNext - 56'(tafg_pkg::NS_PER_SEC);
  // realign: skip an edge if last cycle would fall under half a period
  wire shortCyc = acc < accHalf;
  // drop the boundary edge when the last one is under half a period back
  wire skipEdge = run && shortCyc;
  assign errSet = run && secEdge && !inPhase && !link.refTimeIn.discontinuityMarker ? 1'b0 :
    run && secEdge && inPhase && acc != 56'h0 && !wrap;
  // phase accumulator, edges, status
  always_ff @(posedge mclk)
    if (!rstInt)
    begin
      run <= 1'b0;
      acc <= 56'h0;
      wave <= 1'b0;
      inPhase <= 1'b0;
      skipFlag <= 1'b0;
      cycCount <= 24'h0;
      cyclesLast <= 24'h0;
    end
    else if (clkEn)
    begin
      run <= goodCfg;
      if (!goodCfg)
      begin
        acc <= 56'h0;
        wave <= 1'b0;
        inPhase <= 1'b0;
        cycCount <= 24'h0;
      end
      else if (secEdge)
      begin
        acc <= 56'h0;
        wave <= skipEdge ? wave && halfDuty : 1'b1;
        skipFlag <= skipEdge;
        inPhase <= 1'b1;
        cyclesLast <= cycCount;
        cycCount <= skipEdge ? 24'h0 : 24'h1;
      end
      else
      begin
        if (link.refTimeIn.discontinuityMarker)
          inPhase <= 1'b0;
        acc <= wrap ? accWrapped : accNext;
        if (wrap)
        begin
          wave <= 1'b1;
          cycCount <= cycCount + 24'h1;
        end
        else if (halfDuty)
          wave <= accNext < accHalf ? wave : 1'b0;
        else
          wave <= 1'b0;
      end
    end
  // polarity applied at the pin; while idle with fixed_setup_select clear the live register decides,
  // so a new polarity shows before a run latches it
  wire pinPol = (run || fixed_setup_select) ? cfgPol : regPol;
  assign link.waveOut = wave ~^ pinPol;
  assign link.phaseLockedOut = inPhase;
endmodule

// >>> bench/tafg_link_props.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// link checker: bus handshakes and generated wave
// ------------------------------------------------------------------
module tafg_link_props #(
  parameter bit RESET_POL = 1'b1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic phaseLockedOut,
  input wire logic waveOut
);
  default clocking cb @(posedge mclk);
  endclocking
  logic [31:0] awq; // last write address
  logic [31:0] wq; // last write data
  logic ctlEn; // shadow enable
  logic ctlVal; // shadow valid
  logic pol; // shadow polarity
  wire logic commit; // write accepted with ok
  wire logic polNow; // polarity with a write being answered now
  wire logic run; // generation on
  wire logic active; // wave at active level
  assign commit = bvalid & bready & (bresp == tafg_pkg::RESP_OKAY);
  assign run = ctlEn & ctlVal;
  // the register changes as the answer is raised, so look through it
  assign polNow = (commit && awq == tafg_pkg::OFS_POLARITY) ? wq[0] : pol;
  assign active = (waveOut == polNow);
  // shadow of control and polarity, taken from accepted writes
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      awq <= 32'h00000000;
      wq <= 32'h00000000;
      ctlEn <= 1'b0;
      ctlVal <= 1'b0;
      pol <= RESET_POL;
    end
    else
    begin
      if (awvalid && awready) awq <= awaddr;
      if (wvalid && wready) wq <= wdata;
      if (commit && awq == tafg_pkg::OFS_CONTROL) ctlEn <= wq[tafg_pkg::BIT_ENABLE];
      if (commit && awq == tafg_pkg::OFS_CONTROL) ctlVal <= wq[tafg_pkg::BIT_FREQ_VAL];
      if (commit && awq == tafg_pkg::OFS_POLARITY) pol <= wq[0];
    end
  end
  property p_rst_wave;
    disable iff (1'b0) (!resetn) [*6] |-> waveOut == !RESET_POL;
  endproperty
  a_rst_wave: assert property (p_rst_wave) else $error("wave active in reset");
  property p_rst_lock;
    disable iff (1'b0) (!resetn) [*6] |-> !phaseLockedOut;
  endproperty
  a_rst_lock: assert property (p_rst_lock) else $error("lock set in reset");
  property p_idle;
    disable iff (!resetn) (!run) [*4] |-> waveOut == !polNow;
  endproperty
  a_idle: assert property (p_idle) else $error("wave active while idle");
  property p_half_duty;
    disable iff (!resetn) run && $rose(active) |-> (active || !run) [*8];
  endproperty
  a_half_duty: assert property (p_half_duty) else $error("active phase too short");
  property p_repeat;
    disable iff (!resetn) run && $fell(active) |-> ##[1:80] (active || !run);
  endproperty
  a_repeat: assert property (p_repeat) else $error("no new cycle started");
  property p_bhold;
    disable iff (!resetn) bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    disable iff (!resetn) rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rd_answer;
    disable iff (!resetn) arvalid && arready |=> rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_wr_answer;
    disable iff (!resetn) awvalid && awready && wvalid && wready |-> ##[1:3] bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_decerr;
    disable iff (!resetn) rvalid && rresp == tafg_pkg::RESP_DECERR |-> rdata == 32'h00000000;
  endproperty
  a_decerr: assert property (p_decerr) else $error("refused read data not zero");
endmodule

// >>> bench/testbench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module testbench;
  // ----------------------------------------------------------------
  // clock, reset and host user side
  // ----------------------------------------------------------------
  logic mclk = 1'b0; // system clock
  logic resetn = 1'b0; // sync reset
  logic [31:0] addr = 32'h00000000; // register address
  logic [31:0] wrData = 32'h00000000; // write data
  logic wrStb = 1'b0; // write strobe
  logic rdStb = 1'b0; // read strobe
  logic [31:0] rdData; // read data
  logic busErr; // last answer refused
  logic timeLoad = 1'b0; // time load pulse
  logic [31:0] timeLoadSec = 32'h00000000; // seconds to load
  logic [31:0] timeLoadNs = 32'h00000000; // nanoseconds to load
  tafg_pkg::tafg_setup_t setupIn = '0; // static bundle, unused here
  logic phaseLocked; // in-phase seen by host
  logic wave; // wave seen by host
  logic [31:0] v; // scratch read value
  int errors = 0; // mismatches
  int total_checks = 0; // comparisons
  int rises; // rising edges counted
  int highs; // high cycles counted
  always #10 mclk = ~mclk;
  tafg_link_if link ();
  tafg_host tafg_host_inst (.mclk(mclk), .resetn(resetn), .clkEn(1'b1), .link(link),
    .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .busErr(busErr), .timeLoad(timeLoad), .timeLoadSec(timeLoadSec),
    .timeLoadNs(timeLoadNs), .setupIn(setupIn), .setupEnable(1'b0), .setupValid(1'b0),
    .phaseLocked(phaseLocked), .wave(wave));
  tafg_device tafg_device_inst (.mclk(mclk), .fine_clock_in(1'b0), .resetn(resetn),
    .clkEn(1'b1), .link(link));
  tafg_link_props tafg_link_props_inst (.mclk(mclk), .resetn(resetn),
    .awvalid(link.awvalid), .awready(link.awready), .awaddr(link.awaddr),
    .wvalid(link.wvalid), .wready(link.wready), .wdata(link.wdata),
    .bvalid(link.bvalid), .bready(link.bready), .bresp(link.bresp),
    .arvalid(link.arvalid), .arready(link.arready), .rvalid(link.rvalid),
    .rready(link.rready), .rdata(link.rdata), .rresp(link.rresp),
    .phaseLockedOut(link.phaseLockedOut), .waveOut(link.waveOut));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    d = rdData;
  endtask
  task automatic chk_rd(input string nm, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    `CHK(nm, e, d)
  endtask
  // time source jump to a chosen time
  task automatic load_time(input logic [31:0] s, input logic [31:0] ns);
    @(posedge mclk);
    timeLoadSec <= s;
    timeLoadNs <= ns;
    timeLoad <= 1'b1;
    @(posedge mclk);
    timeLoad <= 1'b0;
  endtask
  // edges and high cycles over 1000 clocks
  task automatic measure;
    logic prev;
    rises = 0;
    highs = 0;
    prev = wave;
    repeat (1000)
    begin
      @(posedge mclk);
      #1;
      if (wave === 1'b1) highs++;
      if (wave === 1'b1 && prev === 1'b0) rises++;
      prev = wave;
    end
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_rd("control", tafg_pkg::OFS_CONTROL, 32'h00000000);
    chk_rd("polarity", tafg_pkg::OFS_POLARITY, 32'h00000001);
    chk_rd("version", tafg_pkg::OFS_VERSION, tafg_pkg::VERSION_VALUE);
    chk_rd("status", tafg_pkg::OFS_STATUS, 32'h00000000);
    `CHK("idle wave", 1'b0, wave)
    chk_rd("unmapped", 32'h00000010, 32'h00000000);
    `CHK("unmapped err", 1'b1, busErr)
    chk_rd("outside", 32'h00010000, 32'h00000000);
    `CHK("outside err", 1'b1, busErr)
    wr(tafg_pkg::OFS_CABLE, 32'hFFFFFFFF);
    chk_rd("cable", tafg_pkg::OFS_CABLE, 32'h0000FFFF);
    `CHK("mapped err", 1'b0, busErr)
    wr(tafg_pkg::OFS_FREQ, 32'hFFFFFFFF);
    chk_rd("freq", tafg_pkg::OFS_FREQ, 32'h00FFFFFF);
    wr(tafg_pkg::OFS_POLARITY, 32'h00000000);
    `CHK("low idle wave", 1'b1, wave)
    wr(tafg_pkg::OFS_POLARITY, 32'hFFFFFFFF);
    chk_rd("pol mask", tafg_pkg::OFS_POLARITY, 32'h00000001);
    `CHK("high idle wave", 1'b0, wave)
    // 1 MHz: 50 clocks per cycle, boundary 300 clocks ahead
    wr(tafg_pkg::OFS_CABLE, 32'h00000000);
    wr(tafg_pkg::OFS_FREQ, 32'h000F4240);
    load_time(32'h00000005, 32'h3B9AB290);
    wr(tafg_pkg::OFS_CONTROL, 32'h00000003);
    repeat (600) @(posedge mclk);
    `CHK("locked", 1'b1, phaseLocked)
    measure();
    `CHK("rises", 20, rises)
    `CHK("highs", 500, highs)
    // jump 10 ns off the grid: out of phase until next second
    load_time(32'h00000006, 32'h3B9AB29A);
    repeat (50) @(posedge mclk);
    `CHK("jump unlocked", 1'b0, phaseLocked)
    measure();
    `CHK("jump rises", 20, rises)
    `CHK("relocked", 1'b1, phaseLocked)
    // reset in mid-run
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (8) @(posedge mclk);
    `CHK("reset wave", 1'b0, wave)
    `CHK("reset lock", 1'b0, phaseLocked)
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_rd("control again", tafg_pkg::OFS_CONTROL, 32'h00000000);
    wr(tafg_pkg::OFS_FREQ, 32'h000F4240);
    wr(tafg_pkg::OFS_CONTROL, 32'h00000001);
    measure();
    `CHK("no valid rises", 0, rises)
    tally_and_finish();
  end
endmodule
